/* File: bcg_bus_clock_ctrl.sv */
// Bus B/C prescalers and per-module bus clock gating behind a Wishbone slave
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "bcg_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// [R1] Bus B tick period is two to the power of its 3-bit code.
// [R2] Bus C tick period is two to the power of its 3-bit code.
// [R3] Bus B divider select resets to zero, undivided.
// [R4] Bus C divider select resets to zero, undivided.
// [R5] System bus mask bit 6 runs the USB clock when set.
// [R6] System bus mask bits 5..3 gate DMA, flash and debug clocks.
// [R7] System bus mask bits 2..0 gate bridges two, one and zero.
// [R8] Bus A mask bits 6..4 gate interrupt controller, calendar, watchdog.
// [R9] Bus A mask bits 3 and 2 gate clock and system controllers.
// [R10] Bus A mask bits 1 and 0 gate power manager and access controller zero.
// [R11] Bus A mask resets with all seven module clocks running.
// [R12] Bus B mask bits 5 and 4 gate USB and DMA clocks.
// [R13] Bus B mask resets with every assigned module clock running.
// [R14] Bus B mask bits 3..0 gate port, flash, debug, access controller one.
// [R15] Writes are blocked while the access controller protects the block.
// [R16] Software reaches divider selects with byte accesses only; the code takes any write that enables byte lane 0, word writes included.
// [R17] Gates and new codes change only on clock period boundaries.
// [R18] Unassigned register bits read zero and ignore writes.
module bcg_bus_clock_ctrl (
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic        wr_protect_i,
   input  wire logic        bus_a_tick_i,
   output logic      [6:0]  sys_bus_en_o,
   output logic      [6:0]  bus_a_en_o,
   output logic      [5:0]  bus_b_en_o,
   output logic             bus_b_tick_o,
   output logic             bus_c_tick_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   bcg_pkg::bcg_code_t       bus_b_sel_r;
   bcg_pkg::bcg_code_t       bus_c_sel_r;
   bcg_pkg::bcg_bus_a_mask_t bus_a_mask_r;
   bcg_pkg::bcg_bus_b_mask_t bus_b_mask_r;
   bcg_pkg::bcg_code_t       code_b_applied;
   bcg_pkg::bcg_code_t       code_c_applied;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone decode

   bcg_pkg::bcg_idx_t idx;
   logic              req;
   logic              wr_lane0;
   logic              wr_ok;
   logic              wr_blocked;
   logic              hit_b_sel;
   logic              hit_c_sel;
   logic              hit_status;
   logic              hit_sys;
   logic              hit_a;
   logic              hit_b_mask;
   logic [31:0]       rd_word;

   assign idx        = wb_adr_i[7:2];
   assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   // Every field sits in byte lane 0, so only that lane carries a write
   assign wr_lane0   = req & wb_we_i & wb_sel_i[0];
   assign wr_ok      = wr_lane0 & ~wr_protect_i; // [R15]
   assign wr_blocked = req & wb_we_i & wr_protect_i; // [R15]

   assign hit_b_sel  = (idx == `BCG_IDX_BUS_B_SEL);
   assign hit_c_sel  = (idx == `BCG_IDX_BUS_C_SEL);
   assign hit_status = (idx == `BCG_IDX_STATUS);
   assign hit_sys    = (idx == `BCG_IDX_SYS_MASK);
   assign hit_a      = (idx == `BCG_IDX_BUS_A_MASK);
   assign hit_b_mask = (idx == `BCG_IDX_BUS_B_MASK);

   // Only assigned bits are stored or returned; the rest reads zero [R18]
   assign rd_word =
      hit_b_sel  ? {29'h0000000, bus_b_sel_r} :
      hit_c_sel  ? {29'h0000000, bus_c_sel_r} :
      hit_status ? {25'h0000000, code_c_applied, 1'b0, code_b_applied} :
      hit_sys    ? {25'h0000000, sys_bus_en_o} :
      hit_a      ? {25'h0000000, bus_a_mask_r} :
      hit_b_mask ? {26'h0000000, bus_b_mask_r} :
      32'h00000000;

   // One wait state: answer in the cycle after the request is seen
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req & ~wr_blocked;
         wb_err_o <= wr_blocked; // [R15]
         wb_dat_o <= (req & ~wb_we_i) ? rd_word : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         bus_b_sel_r <= `BCG_RST_CODE; // [R3]
         bus_c_sel_r <= `BCG_RST_CODE; // [R4]
      end else begin
         if (wr_ok & hit_b_sel) begin
            bus_b_sel_r <= wb_dat_i[`BCG_CODE_W-1:0]; // [R1] [R16]
         end
         if (wr_ok & hit_c_sel) begin
            bus_c_sel_r <= wb_dat_i[`BCG_CODE_W-1:0]; // [R2] [R16]
         end
      end
   end

   // The system bus runs on the main clock, so every edge is a boundary
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sys_bus_en_o <= `BCG_RST_SYS_MASK;
      end else if (wr_ok & hit_sys) begin
         sys_bus_en_o <= wb_dat_i[`BCG_SYS_W-1:0]; // [R5] [R6] [R7] [R17]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         bus_a_mask_r <= `BCG_RST_BUS_A_MASK; // [R11]
         bus_b_mask_r <= `BCG_RST_BUS_B_MASK; // [R13]
      end else begin
         if (wr_ok & hit_a) begin
            bus_a_mask_r <= wb_dat_i[`BCG_BUS_A_W-1:0]; // [R18]
         end
         if (wr_ok & hit_b_mask) begin
            bus_b_mask_r <= wb_dat_i[`BCG_BUS_B_W-1:0]; // [R18]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescalers

   bcg_prescaler #(
      .CODE_W (`BCG_CODE_W)
   ) u_presc_b (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .code_i    (bus_b_sel_r),
      .tick_o    (bus_b_tick_o),
      .code_o    (code_b_applied)
   ); // [R1] [R17]

   bcg_prescaler #(
      .CODE_W (`BCG_CODE_W)
   ) u_presc_c (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .code_i    (bus_c_sel_r),
      .tick_o    (bus_c_tick_o),
      .code_o    (code_c_applied)
   ); // [R2] [R17]

   ////////////////////////////////////////////////////////////////////////////
   // Gated clock enables
   // Gating a tick rather than a clock means a mask change can only drop or
   // pass whole periods, never cut one short

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         bus_a_en_o <= 7'h00;
         bus_b_en_o <= 6'h00;
      end else begin
         bus_a_en_o <= {`BCG_BUS_A_W{bus_a_tick_i}} & bus_a_mask_r; // [R8] [R9] [R10] [R17]
         bus_b_en_o <= {`BCG_BUS_B_W{bus_b_tick_o}} & bus_b_mask_r; // [R12] [R14] [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   // Cycles since the last tick and the code that tick started; armed skips
   // the first tick after reset, whose spacing is not a whole period
   logic [8:0]         gap_b_r;
   logic [8:0]         gap_c_r;
   bcg_pkg::bcg_code_t per_b_r;
   bcg_pkg::bcg_code_t per_c_r;
   logic               armed_b_r;
   logic               armed_c_r;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         gap_b_r   <= 9'h001;
         gap_c_r   <= 9'h001;
         per_b_r   <= 3'h0;
         per_c_r   <= 3'h0;
         armed_b_r <= 1'b0;
         armed_c_r <= 1'b0;
      end else begin
         gap_b_r <= bus_b_tick_o ? 9'h001 : gap_b_r + 9'h001;
         gap_c_r <= bus_c_tick_o ? 9'h001 : gap_c_r + 9'h001;
         if (bus_b_tick_o) begin
            per_b_r   <= code_b_applied;
            armed_b_r <= 1'b1;
         end
         if (bus_c_tick_o) begin
            per_c_r   <= code_c_applied;
            armed_c_r <= 1'b1;
         end
      end
   end

   b_period_a: assert property ( // [R1]
      bus_b_tick_o && armed_b_r |-> gap_b_r == (9'h001 << per_b_r))
      else $error("bus B tick period does not match its code");

   c_period_a: assert property ( // [R2]
      bus_c_tick_o && armed_c_r |-> gap_c_r == (9'h001 << per_c_r))
      else $error("bus C tick period does not match its code");

   sel_reset_a: assert property ( // [R3] [R4]
      $fell(srst_i) |-> bus_b_sel_r == 3'h0 && bus_c_sel_r == 3'h0
         ##1 bus_b_tick_o && bus_c_tick_o ##1 bus_b_tick_o && bus_c_tick_o)
      else $error("divider selects not undivided after reset");

   mask_reset_a: assert property ( // [R11] [R13]
      $fell(srst_i) |-> bus_a_mask_r == 7'h7f && bus_b_mask_r == 6'h3f
         && sys_bus_en_o == 7'h7f)
      else $error("gate masks not all running after reset");

   sys_write_a: assert property ( // [R5] [R6] [R7]
      wr_ok && hit_sys |=> sys_bus_en_o == $past(wb_dat_i[6:0]))
      else $error("system bus gates do not follow a mask write");

   bus_a_gate_a: assert property ( // [R8] [R9] [R10]
      ##1 bus_a_en_o == ({7{$past(bus_a_tick_i)}} & $past(bus_a_mask_r)))
      else $error("bus A enable not gated by its mask");

   bus_b_gate_a: assert property ( // [R12] [R14]
      ##1 bus_b_en_o == ({6{$past(bus_b_tick_o)}} & $past(bus_b_mask_r)))
      else $error("bus B enable not gated by its mask");

   protect_a: assert property ( // [R15]
      wr_blocked |=> wb_err_o && !wb_ack_o && $stable(bus_b_sel_r)
         && $stable(bus_a_mask_r) && $stable(sys_bus_en_o))
      else $error("protected write was not refused");

   code_boundary_a: assert property ( // [R17]
      $changed(code_b_applied) |-> bus_b_tick_o)
      else $error("bus B code changed inside a period");

   zero_bits_a: assert property ( // [R18]
      wb_ack_o |-> wb_dat_o[31:7] == 25'h0000000)
      else $error("unassigned bits read non-zero");

   answer_a: assert property (
      req |=> (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o && !wb_err_o)
      else $error("bus answer not a single one-cycle pulse");

   idle_data_a: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data shown outside an acknowledge");

   err_cause_a: assert property ( // [R15]
      wb_err_o |-> $past(wr_blocked))
      else $error("error answer without a protected write");

   out_reset_a: assert property (
      $fell(srst_i) |-> !wb_ack_o && !wb_err_o && wb_dat_o == 32'h00000000
         && bus_a_en_o == 7'h00 && bus_b_en_o == 6'h00)
      else $error("bus answer or module enables active after reset");

   ////////////////////////////////////////////////////////////////////////////
   // Register write paths
   // Each stored field must equal the lane 0 data of the write that hit it

   b_sel_write_a: assert property ( // [R1]
      wr_ok && hit_b_sel |=> bus_b_sel_r == $past(wb_dat_i[2:0]))
      else $error("bus B divider select does not follow a write");

   c_sel_write_a: assert property ( // [R2]
      wr_ok && hit_c_sel |=> bus_c_sel_r == $past(wb_dat_i[2:0]))
      else $error("bus C divider select does not follow a write");

   a_mask_write_a: assert property ( // [R8] [R9] [R10]
      wr_ok && hit_a |=> bus_a_mask_r == $past(wb_dat_i[6:0]))
      else $error("bus A gate mask does not follow a write");

   b_mask_write_a: assert property ( // [R12] [R14]
      wr_ok && hit_b_mask |=> bus_b_mask_r == $past(wb_dat_i[5:0]))
      else $error("bus B gate mask does not follow a write");

   // Nothing but an accepted write may move a mask; a stray change would
   // stop a module clock behind software's back
   sys_hold_a: assert property ( // [R17]
      $changed(sys_bus_en_o) |-> $past(wr_ok) && $past(hit_sys))
      else $error("system bus gates changed without a write");

   mask_hold_a: assert property ( // [R18]
      $changed(bus_a_mask_r) || $changed(bus_b_mask_r) |-> $past(wr_ok))
      else $error("bus A or B gate mask changed without a write");

   lane_guard_a: assert property (
      req && wb_we_i && !wb_sel_i[0] |=> $stable(bus_b_sel_r) && $stable(bus_c_sel_r)
         && $stable(sys_bus_en_o) && $stable(bus_a_mask_r) && $stable(bus_b_mask_r))
      else $error("write without lane 0 changed a register");

   ////////////////////////////////////////////////////////////////////////////
   // Tick shape
   // Above code 0 a tick must last one cycle, or a module would see two
   // clock edges where one was meant

   b_pulse_a: assert property ( // [R1]
      bus_b_tick_o && code_b_applied != 3'h0 |=> !bus_b_tick_o)
      else $error("bus B tick longer than one cycle");

   c_pulse_a: assert property ( // [R2]
      bus_c_tick_o && code_c_applied != 3'h0 |=> !bus_c_tick_o)
      else $error("bus C tick longer than one cycle");

   c_boundary_a: assert property ( // [R17]
      $changed(code_c_applied) |-> bus_c_tick_o)
      else $error("bus C code changed inside a period");

   slow_b_c: cover property (bus_b_tick_o && armed_b_r && per_b_r == 3'h7);
   slow_c_c: cover property (bus_c_tick_o && armed_c_r && per_c_r == 3'h7);
   blocked_c: cover property (wr_blocked);
   usb_gate_c: cover property (bus_b_tick_o && !bus_b_mask_r[`BCG_B_USB_BIT]);
   c_change_c: cover property ($changed(code_c_applied));

endmodule

/* File: bcg_cfg.svh */
// Offsets, field positions, reset values and widths of the bus clock controller
`ifndef BCG_CFG_SVH
`define BCG_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define BCG_IDX_BUS_B_SEL   6'h0a
`define BCG_IDX_BUS_C_SEL   6'h0b
`define BCG_IDX_STATUS      6'h0c
`define BCG_IDX_SYS_MASK    6'h14
`define BCG_IDX_BUS_A_MASK  6'h18
`define BCG_IDX_BUS_B_MASK  6'h1c

// Field widths and positions
`define BCG_CODE_W          3
`define BCG_CODE_LSB        0
`define BCG_STAT_C_LSB      4
`define BCG_SYS_W           7
`define BCG_BUS_A_W         7
`define BCG_BUS_B_W         6

// Gate bit positions, system bus mask
`define BCG_SYS_USB_BIT     6
`define BCG_SYS_DMA_BIT     5
`define BCG_SYS_FLASH_BIT   4
`define BCG_SYS_DEBUG_BIT   3
`define BCG_SYS_BRIDGE2_BIT 2
`define BCG_SYS_BRIDGE1_BIT 1
`define BCG_SYS_BRIDGE0_BIT 0

// Gate bit positions, bus B mask
`define BCG_B_USB_BIT       5
`define BCG_B_DMA_BIT       4
`define BCG_B_PORT_BIT      3

// Reset values
`define BCG_RST_CODE        3'h0
`define BCG_RST_SYS_MASK    7'h7f
`define BCG_RST_BUS_A_MASK  7'h7f
`define BCG_RST_BUS_B_MASK  6'h3f

`endif

/* File: bcg_periph_model.sv */
// Peripheral-side model: counts the clock-enable pulses each module receives
`timescale 1ns/1ps
module bcg_periph_model #(
   parameter int W = 7
) (
   input  wire logic               sys_clk_i,
   input  wire logic               srst_i,
   input  wire logic [W-1:0]       en_i,
   output logic      [W-1:0][15:0] cnt_o
);
   // A stopped module sees no pulse, so its count freezes
   always_ff @(posedge sys_clk_i) begin
      for (int i = 0; i < W; i++) begin
         if (srst_i) begin
            cnt_o[i] <= 16'h0;
         end else if (en_i[i]) begin
            cnt_o[i] <= cnt_o[i] + 16'h1;
         end
      end
   end
endmodule

/* File: bcg_pkg.sv */
// Types shared by the bus clock controller files
`include "bcg_cfg.svh"
package bcg_pkg;
   typedef logic [`BCG_CODE_W-1:0]  bcg_code_t;
   typedef logic [`BCG_SYS_W-1:0]   bcg_sys_mask_t;
   typedef logic [`BCG_BUS_A_W-1:0] bcg_bus_a_mask_t;
   typedef logic [`BCG_BUS_B_W-1:0] bcg_bus_b_mask_t;
   typedef logic [5:0]              bcg_idx_t;
endpackage

/* File: bcg_prescaler.sv */
// Power-of-two prescaler producing a one-cycle tick, code applied at period ends
`timescale 1ns/1ps
`include "bcg_cfg.svh"
module bcg_prescaler #(
   parameter int CODE_W = `BCG_CODE_W
) (
   input  wire logic              sys_clk_i,
   input  wire logic              srst_i,
   input  wire logic [CODE_W-1:0] code_i,
   output logic                   tick_o,
   output logic [CODE_W-1:0]      code_o
);
   localparam int CNT_W = (1 << CODE_W) - 1;

   if (CODE_W < 1 || CODE_W > 4) begin : g_chk
      $error("bcg_prescaler: CODE_W must be 1 to 4");
   end

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] one;
   logic [CNT_W-1:0] limit;
   logic             wrap;

   assign one   = {{(CNT_W-1){1'b0}}, 1'b1};
   assign limit = (one << code_o) - one;
   assign wrap  = (cnt_r == limit);

   // A new code is taken only when a period ends, so no short period appears
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cnt_r  <= '0;
         code_o <= CODE_W'(`BCG_RST_CODE);
         tick_o <= 1'b0;
      end else begin
         tick_o <= wrap;
         cnt_r  <= wrap ? '0 : cnt_r + one;
         if (wrap) begin
            code_o <= code_i;
         end
      end
   end
endmodule

/* File: test_bcg_bus_clock_ctrl.sv */
// Testbench for the bus clock controller
`timescale 1ns/1ps
module test_bcg_bus_clock_ctrl;
   logic             sys_clk, srst, cyc, stb, we, prot, a_tick, ack, err, e, b_tick, c_tick;
   logic [7:0]       adr;
   logic [3:0]       sel;
   logic [31:0]      wdat, rdat, q;
   logic [6:0]       sys_en, a_en;
   logic [5:0]       b_en;
   logic [6:0][15:0] cnt_a, cnt_b, s_a, s_b;
   int               error_cnt, checks_done;
   logic [7:0]       ra [5]  = '{8'h28, 8'h2c, 8'h50, 8'h60, 8'h70};
   logic [31:0]      rv [5]  = '{32'h0, 32'h0, 32'h7f, 32'h7f, 32'h3f};
   logic [6:0]       pat [3] = '{7'h55, 7'h2a, 7'h7f};

   bcg_bus_clock_ctrl DUT (.sys_clk_i(sys_clk), .srst_i(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err), .wr_protect_i(prot), .bus_a_tick_i(a_tick),
      .sys_bus_en_o(sys_en), .bus_a_en_o(a_en), .bus_b_en_o(b_en), .bus_b_tick_o(b_tick),
      .bus_c_tick_o(c_tick));
   bcg_periph_model pa (.sys_clk_i(sys_clk), .srst_i(srst), .en_i(a_en), .cnt_o(cnt_a));
   bcg_periph_model pb (.sys_clk_i(sys_clk), .srst_i(srst), .en_i({1'b0, b_en}), .cnt_o(cnt_b));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Bus A prescaler stand-in: a pulse every second cycle
   always @(posedge sys_clk) a_tick <= srst ? 1'b0 : ~a_tick;

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Classic cycle: hold until ack or err is sampled, then release
   task wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 100);
      q = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      chk("answer", 32'(ack | err), 32'h1);
   endtask

   task gate(input logic [7:0] a, input logic [6:0] m);
      logic [6:0] act, exp;
      exp = (a == 8'h70) ? (m & 7'h3f) : m;
      wb(a, 1'b1, 4'hf, 32'hffffff80 | 32'(m));
      wb(a, 1'b0, 4'hf, 32'h0);
      chk("mask", q, 32'(exp));
      repeat (4) @(posedge sys_clk);
      s_a = cnt_a;
      s_b = cnt_b;
      repeat (32) @(posedge sys_clk);
      for (int i = 0; i < 7; i++) act[i] = (a == 8'h60) ? (cnt_a[i] !== s_a[i]) : (cnt_b[i] !== s_b[i]);
      if (a == 8'h50) act = sys_en;
      chk("gates", 32'(act), 32'(exp));
   endtask

   // Third spacing is taken, so the old period has surely ended
   task div(input int k);
      int n;
      for (int c = 0; c < 8; c++) begin
         wb(k ? 8'h2c : 8'h28, 1'b1, 4'h1, 32'(c));
         for (int t = 0; t < 3; t++) begin
            n = 0;
            do begin
               @(posedge sys_clk);
               n++;
            end while ((k ? c_tick : b_tick) !== 1'b1 && n < 300);
         end
         chk("period", 32'(n), 32'h1 << c);
         wb(8'h30, 1'b0, 4'hf, 32'h0);
         chk("status", q, k ? (32'h7 | (32'(c) << 4)) : 32'(c));
      end
   endtask

   task results;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      results;
   end

   initial begin
      srst = 1'b1;
      {cyc, stb, we, prot} = 4'h0;
      adr = 8'h0;
      sel = 4'h0;
      wdat = 32'h0;
      error_cnt = 0;
      checks_done = 0;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      chk("sys en", 32'(sys_en), 32'h7f);
      for (int i = 0; i < 5; i++) begin
         wb(ra[i], 1'b0, 4'hf, 32'h0);
         chk("reset value", q, rv[i]);
      end
      $display("test reset done");
      for (int p = 0; p < 3; p++) begin
         for (int i = 2; i < 5; i++) gate(ra[i], pat[p]);
      end
      $display("test gating done");
      div(0);
      div(1);
      $display("test dividers done");
      prot <= 1'b1;
      wb(8'h50, 1'b1, 4'hf, 32'h0);
      prot <= 1'b0;
      chk("err", 32'(e), 32'h1);
      wb(8'h50, 1'b0, 4'hf, 32'h0);
      chk("protected", q, 32'h7f);
      wb(8'h50, 1'b1, 4'he, 32'h0);
      wb(8'h50, 1'b0, 4'hf, 32'h0);
      chk("lane 0 only", q, 32'h7f);
      wb(8'h40, 1'b1, 4'hf, 32'hffffffff);
      wb(8'h40, 1'b0, 4'hf, 32'h0);
      chk("unmapped", q, 32'h0);
      $display("test protect done");
      // Reset in mid-run from a non-default state: stopped bus A, slowest codes
      wb(8'h60, 1'b1, 4'hf, 32'h0);
      srst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wb(ra[i], 1'b0, 4'hf, 32'h0);
         chk("reset again", q, rv[i]);
      end
      $display("test reset again done");
      results;
   end
endmodule
